// [inc/sgr_pkg.sv]
// constants and types shared by the software interrupt generation block
package sgr_pkg;

   // write-encoding of the two generation registers
   localparam logic [1:0] SYS_OP0       = 2'h3;
   localparam logic [2:0] SYS_OP1       = 3'h0;
   localparam logic [3:0] SYS_CRN       = 4'hC;
   localparam logic [3:0] SYS_CRM       = 4'hB;
   localparam logic [2:0] SYS_OP2_GRP0  = 3'h7;
   localparam logic [2:0] SYS_OP2_GRP1  = 3'h5;

   // field positions of the written value
   localparam int AFFINITY_LEVEL3_LSB   = 48;
   localparam int RANGE_LSB  = 44;
   localparam int BCAST_BIT  = 40;
   localparam int AFFINITY_LEVEL2_LSB   = 32;
   localparam int INTERRUPT_IDENTIFIER_LSB  = 24;
   localparam int AFFINITY_LEVEL1_LSB   = 16;
   localparam int TLIST_LSB  = 0;
   localparam int AFF_W      = 8;
   localparam int RANGE_W    = 4;
   localparam int INTERRUPT_IDENTIFIER_W    = 4;
   localparam int TLIST_W    = 16;
   localparam int CLUSTER_SZ = 16;
   localparam int AFF0_W     = 8;

   // syndrome class of a system register access trap
   localparam logic [5:0] TRAP_SYNDROME = 6'h18;

   // exception levels
   localparam logic [1:0] EL0 = 2'h0;
   localparam logic [1:0] EL1 = 2'h1;
   localparam logic [1:0] EL2 = 2'h2;
   localparam logic [1:0] EL3 = 2'h3;

   // monitor routing field value sending both irq and fiq to level 3
   localparam logic [1:0] MON_ROUTE_BOTH = 2'h3;

   // outcome of an access check
   typedef enum logic [2:0]
   {
      SGR_ACC_PERFORM = 3'b000,
      SGR_ACC_UNDEF   = 3'b001,
      SGR_ACC_TRAP1   = 3'b010,
      SGR_ACC_TRAP2   = 3'b011,
      SGR_ACC_TRAP3   = 3'b100,
      SGR_ACC_NONE    = 3'b101
   } sgr_acc_e;

   // request state toward the distributor
   typedef enum logic [0:0]
   {
      SGR_IDLE = 1'b0,
      SGR_SEND = 1'b1
   } sgr_state_e;

endpackage

// [core/sgr_access_check.sv]
// access check for writes to the generation registers
`timescale 1ns/1ps
`default_nettype none
module sgr_access_check
(
   input  wire logic [1:0]      curEl,
   input  wire logic            el2Enabled,
   input  wire logic            el3Present,
   input  wire logic            halted,
   input  wire logic            secureDebugDisabled,
   input  wire logic            earlyUndefOption,
   input  wire logic            sreEl1,
   input  wire logic            sreEl2,
   input  wire logic            sreEl3,
   input  wire logic            commonRegisterTrap,
   input  wire logic            fiqRouteOverride,
   input  wire logic            irqRouteOverride,
   input  wire logic [1:0]      monitorIrqFiqRoute,
   output var sgr_pkg::sgr_acc_e verdict
);
   logic monBoth;
   logic undefDbg;

   assign monBoth  = el3Present && (monitorIrqFiqRoute == sgr_pkg::MON_ROUTE_BOTH);
   assign undefDbg = halted && secureDebugDisabled;

   // priority chain per level; enable check precedes hypervisor and monitor
   always_comb
   begin
      verdict = sgr_pkg::SGR_ACC_PERFORM;
      unique case (curEl)
         sgr_pkg::EL0: verdict = sgr_pkg::SGR_ACC_UNDEF;
         sgr_pkg::EL1:
         begin
            if (undefDbg && earlyUndefOption && monBoth) verdict = sgr_pkg::SGR_ACC_UNDEF;
            else if (!sreEl1) verdict = sgr_pkg::SGR_ACC_TRAP1;
            else if (el2Enabled && commonRegisterTrap) verdict = sgr_pkg::SGR_ACC_TRAP2;
            else if (el2Enabled && fiqRouteOverride) verdict = sgr_pkg::SGR_ACC_TRAP2;
            else if (el2Enabled && irqRouteOverride) verdict = sgr_pkg::SGR_ACC_TRAP2;
            else if (monBoth)
               verdict = undefDbg ? sgr_pkg::SGR_ACC_UNDEF : sgr_pkg::SGR_ACC_TRAP3;
         end
         sgr_pkg::EL2:
         begin
            if (undefDbg && earlyUndefOption && monBoth) verdict = sgr_pkg::SGR_ACC_UNDEF;
            else if (!sreEl2) verdict = sgr_pkg::SGR_ACC_TRAP2;
            else if (monBoth)
               verdict = undefDbg ? sgr_pkg::SGR_ACC_UNDEF : sgr_pkg::SGR_ACC_TRAP3;
         end
         sgr_pkg::EL3:
         begin
            if (!sreEl3) verdict = sgr_pkg::SGR_ACC_TRAP3;
         end
      endcase
   end

endmodule // sgr_access_check
`default_nettype wire

// [core/sgr_target_expand.sv]
// expands a target bitmap into a mask over the level-0 affinity space
`timescale 1ns/1ps
`default_nettype none
module sgr_target_expand
(
   input  wire logic [3:0]    rangeSelector,
   input  wire logic [15:0]   targetBitmap,
   input  wire logic [255:0]  validAff0,
   output logic [255:0]       aff0Mask
);
   // bit n lands at selector*16+n; invalid entries are dropped
   always_comb
   begin
      aff0Mask = '0;
      for (int n = 0; n < sgr_pkg::CLUSTER_SZ; n++)
      begin
         aff0Mask[{rangeSelector, 4'(n)}] = targetBitmap[n];
      end
      aff0Mask = aff0Mask & validAff0;
   end

endmodule // sgr_target_expand
`default_nettype wire

// [core/sgr_generate.sv]
// software interrupt generation from writes of the two generation registers
//
// Overview of operation
// - affinity path from bits 55:48, 39:32, 23:16
// - range selector picks sixteen-wide level-0 block
// - selector reads as zero without cpu support
// - unsupported nonzero selector: drop or zero
// - bit 40 selects broadcast except writer
// - identifier taken from bits 27:24
// - bitmap bit n selects level-0 affinity n
// - bitmap bits without valid target ignored
// - without selector only affinity below sixteen
// - distributor always accepts, acknowledges, may discard
// - group 0 nonsecure writes need access permission
// - security enabled: forbidden nonsecure targets skipped
// - level 3 writes always count as secure
// - group 1 uses writer's state, maybe group 0
// - write-only, encoded 3,0,12,11 with op2 7/5
// - level 0 writes are undefined
// - level 1 disabled interface traps level 1
// - hypervisor trap, fiq, irq route trap level 2
// - monitor routing traps level 3, or undefined
// - level 2 disabled interface traps level 2
// - level 3 disabled interface traps level 3
`timescale 1ns/1ps
`default_nettype none
module sgr_generate
(
   input  wire logic            clk_sys,
   input  wire logic            rstn,
   // system register write port
   input  wire logic            sysWrValid,
   input  wire logic [1:0]      sysOp0,
   input  wire logic [2:0]      sysOp1,
   input  wire logic [3:0]      sysCrn,
   input  wire logic [3:0]      sysCrm,
   input  wire logic [2:0]      sysOp2,
   input  wire logic [63:0]     sysWrData,
   // processor state
   input  wire logic [1:0]      curEl,
   input  wire logic            monitorNonsecureBit,
   input  wire logic            el2Enabled,
   input  wire logic            el3Present,
   input  wire logic            halted,
   input  wire logic            secureDebugDisabled,
   input  wire logic            earlyUndefOption,
   input  wire logic            sreEl1,
   input  wire logic            sreEl2,
   input  wire logic            sreEl3,
   input  wire logic            commonRegisterTrap,
   input  wire logic            fiqRouteOverride,
   input  wire logic            irqRouteOverride,
   input  wire logic [1:0]      monitorIrqFiqRoute,
   // configuration
   input  wire logic            cpuRangeSelectSupport,
   input  wire logic            distRangeSelectSupport,
   input  wire logic            dropOnBadRange,
   input  wire logic            disableSecurity,
   input  wire logic            grp1AsGroup0,
   // access outcome
   output logic                 accUndefined,
   output logic                 accTrap,
   output logic [1:0]           accTrapEl,
   output logic [5:0]           accSyndrome,
   // request toward distributor
   output logic                 sgiReqValid,
   input  wire logic            sgiReqReady,
   output logic [7:0]           reqAffinityLevel3,
   output logic [7:0]           reqAffinityLevel2,
   output logic [7:0]           reqAffinityLevel1,
   output logic [3:0]           reqRangeSelector,
   output logic [15:0]          reqTargetBitmap,
   output logic [3:0]           reqInterruptIdentifier,
   output logic                 reqBroadcast,
   output logic                 reqGroup0,
   output logic                 reqSecure,
   output logic                 reqNonsecureCheck
);
   typedef struct packed
   {
      sgr_pkg::sgr_state_e state;
      logic       undef;
      logic       trap;
      logic [1:0] trapEl;
      logic [7:0] affinity_level3;
      logic [7:0] affinity_level2;
      logic [7:0] affinity_level1;
      logic [3:0] rsel;
      logic [15:0] tlist;
      logic [3:0] interrupt_identifier;
      logic       bcast;
      logic       grp0;
      logic       secure;
      logic       nsCheck;
   } sgr_state_s;

   sgr_state_s          st;
   sgr_state_s          next_st;
   sgr_pkg::sgr_acc_e   verdict;
   logic                hitGrp0;
   logic                hitGrp1;
   logic                isSecure;
   logic [3:0]          effRange;
   logic                dropWrite;
   logic [255:0]        validAff0;
   logic [255:0]        aff0Mask;

   // checks the level, enable and trap controls
   sgr_access_check uCheck
   (
      .curEl              (curEl),
      .el2Enabled         (el2Enabled),
      .el3Present         (el3Present),
      .halted             (halted),
      .secureDebugDisabled(secureDebugDisabled),
      .earlyUndefOption   (earlyUndefOption),
      .sreEl1             (sreEl1),
      .sreEl2             (sreEl2),
      .sreEl3             (sreEl3),
      .commonRegisterTrap (commonRegisterTrap),
      .fiqRouteOverride   (fiqRouteOverride),
      .irqRouteOverride   (irqRouteOverride),
      .monitorIrqFiqRoute (monitorIrqFiqRoute),
      .verdict            (verdict)
   );

   // register decode; other encodings are not this block's
   function automatic logic encHit(input logic [2:0] op2);
      encHit = sysWrValid && (sysOp0 == sgr_pkg::SYS_OP0) && (sysOp1 == sgr_pkg::SYS_OP1)
               && (sysCrn == sgr_pkg::SYS_CRN) && (sysCrm == sgr_pkg::SYS_CRM)
               && (sysOp2 == op2);
   endfunction

   assign hitGrp0 = encHit(sgr_pkg::SYS_OP2_GRP0);
   assign hitGrp1 = encHit(sgr_pkg::SYS_OP2_GRP1);

   // level 3 is always secure regardless of the monitor bit
   assign isSecure = (curEl == sgr_pkg::EL3) || !monitorNonsecureBit;

   // selector forced to zero without cpu support; without distributor support
   // a nonzero selector is either dropped or zeroed, picked by a strap
   always_comb
   begin
      effRange  = sysWrData[sgr_pkg::RANGE_LSB +: sgr_pkg::RANGE_W];
      dropWrite = 1'b0;
      if (!cpuRangeSelectSupport)
      begin
         effRange = '0;
      end
      else if (!distRangeSelectSupport && (effRange != '0))
      begin
         dropWrite = dropOnBadRange;
         effRange  = '0;
      end
   end

   // next-state: one request held until the distributor takes it
   always_comb
   begin
      next_st       = st;
      next_st.undef = 1'b0;
      next_st.trap  = 1'b0;
      if ((st.state == sgr_pkg::SGR_SEND) && sgiReqReady)
      begin
         next_st.state = sgr_pkg::SGR_IDLE;
      end
      if ((hitGrp0 || hitGrp1) && (next_st.state == sgr_pkg::SGR_IDLE))
      begin
         unique case (verdict)
            sgr_pkg::SGR_ACC_UNDEF:  next_st.undef = 1'b1;
            sgr_pkg::SGR_ACC_TRAP1:
            begin
               next_st.trap   = 1'b1;
               next_st.trapEl = sgr_pkg::EL1;
            end
            sgr_pkg::SGR_ACC_TRAP2:
            begin
               next_st.trap   = 1'b1;
               next_st.trapEl = sgr_pkg::EL2;
            end
            sgr_pkg::SGR_ACC_TRAP3:
            begin
               next_st.trap   = 1'b1;
               next_st.trapEl = sgr_pkg::EL3;
            end
            sgr_pkg::SGR_ACC_PERFORM:
            begin
               if (!dropWrite)
               begin
                  next_st.state = sgr_pkg::SGR_SEND;
                  // reserved bits never reach the request
                  next_st.affinity_level3  = sysWrData[sgr_pkg::AFFINITY_LEVEL3_LSB +: sgr_pkg::AFF_W];
                  next_st.affinity_level2  = sysWrData[sgr_pkg::AFFINITY_LEVEL2_LSB +: sgr_pkg::AFF_W];
                  next_st.affinity_level1  = sysWrData[sgr_pkg::AFFINITY_LEVEL1_LSB +: sgr_pkg::AFF_W];
                  next_st.rsel  = effRange;
                  next_st.tlist = sysWrData[sgr_pkg::TLIST_LSB +: sgr_pkg::TLIST_W];
                  next_st.interrupt_identifier = sysWrData[sgr_pkg::INTERRUPT_IDENTIFIER_LSB +: sgr_pkg::INTERRUPT_IDENTIFIER_W];
                  next_st.bcast = sysWrData[sgr_pkg::BCAST_BIT];
                  next_st.secure = isSecure;
                  // group 1 writes may become group 0 under a security strap
                  next_st.grp0  = hitGrp0 || grp1AsGroup0;
                  // nonsecure group 0 needs per-target permission at the far end, unless security is disabled
                  next_st.nsCheck = !isSecure && !disableSecurity && next_st.grp0;
               end
            end
            default: ;
         endcase
      end
   end

   // one register for all state
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign sgiReqValid            = (st.state == sgr_pkg::SGR_SEND);
   // broadcast hides affinity path and bitmap
   assign reqAffinityLevel3      = st.bcast ? '0 : st.affinity_level3;
   assign reqAffinityLevel2      = st.bcast ? '0 : st.affinity_level2;
   assign reqAffinityLevel1      = st.bcast ? '0 : st.affinity_level1;
   assign reqRangeSelector       = st.bcast ? '0 : st.rsel;
   assign reqTargetBitmap        = st.bcast ? '0 : st.tlist;
   assign reqInterruptIdentifier = st.interrupt_identifier;
   assign reqBroadcast           = st.bcast;
   assign reqGroup0              = st.grp0;
   assign reqSecure              = st.secure;
   assign reqNonsecureCheck      = st.nsCheck;
   assign accUndefined           = st.undef;
   assign accTrap                = st.trap;
   assign accTrapEl              = st.trapEl;
   assign accSyndrome            = st.trap ? sgr_pkg::TRAP_SYNDROME : '0;

   // reachable level-0 space: without cpu selector support only the first block
   assign validAff0 = cpuRangeSelectSupport ? '1
                      : {{($bits(validAff0) - sgr_pkg::CLUSTER_SZ){1'b0}},
                         {sgr_pkg::CLUSTER_SZ{1'b1}}};

   // expanded target mask of the pending request; the distributor does the
   // real per-target filtering, this copy lets the mapping be checked here
   sgr_target_expand uExpand
   (
      .rangeSelector (st.rsel),
      .targetBitmap  (st.tlist),
      .validAff0     (validAff0),
      .aff0Mask      (aff0Mask)
   );

   // a_el0_undef: level 0 write gives undefined next cycle
   a_el0_undef: assert property (@(posedge clk_sys) disable iff (!rstn)
      (hitGrp0 && curEl == sgr_pkg::EL0 && !sgiReqValid) |=> accUndefined && !sgiReqValid)
      else $error("level 0 write not undefined");
   a_el1_trap: assert property (@(posedge clk_sys) disable iff (!rstn)
      (hitGrp1 && curEl == sgr_pkg::EL1 && !sreEl1 && !halted && !sgiReqValid)
      |=> accTrap && accTrapEl == sgr_pkg::EL1)
      else $error("level 1 trap missing");
   // halted excluded: the early undefined check may win over the trap
   a_el2_trap: assert property (@(posedge clk_sys) disable iff (!rstn)
      (hitGrp0 && curEl == sgr_pkg::EL1 && sreEl1 && el2Enabled && commonRegisterTrap
       && !halted && !sgiReqValid)
      |=> accTrap && accTrapEl == sgr_pkg::EL2)
      else $error("level 2 trap missing");
   a_el3_trap: assert property (@(posedge clk_sys) disable iff (!rstn)
      (hitGrp0 && curEl == sgr_pkg::EL3 && !sreEl3 && !sgiReqValid)
      |=> accTrap && accTrapEl == sgr_pkg::EL3)
      else $error("level 3 trap missing");
   a_interrupt_identifier_take: assert property (@(posedge clk_sys) disable iff (!rstn)
      (verdict == sgr_pkg::SGR_ACC_PERFORM && hitGrp1 && !dropWrite && !sgiReqValid)
      |=> sgiReqValid && reqInterruptIdentifier == $past(sysWrData[27:24]))
      else $error("identifier not captured");
   a_el3_secure: assert property (@(posedge clk_sys) disable iff (!rstn)
      (sgiReqValid && !$past(sgiReqValid) && $past(curEl) == sgr_pkg::EL3) |-> reqSecure)
      else $error("level 3 write not secure");
   a_bcast_hide: assert property (@(posedge clk_sys) disable iff (!rstn)
      (sgiReqValid && reqBroadcast) |-> reqTargetBitmap == '0 && reqAffinityLevel1 == '0)
      else $error("broadcast leaks path");
   a_range_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
      sgiReqValid && !$past(sgiReqValid) && !$past(cpuRangeSelectSupport)
      |-> reqRangeSelector == '0)
      else $error("selector not zero");
   a_req_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      (sgiReqValid && !sgiReqReady) |=> sgiReqValid && $stable(reqInterruptIdentifier))
      else $error("request dropped before accept");
   // bitmap lands in the selected sixteen-wide block and nowhere else
   a_mask_map: assert property (@(posedge clk_sys) disable iff (!rstn)
      (sgiReqValid && !reqBroadcast)
      |-> aff0Mask[{reqRangeSelector, 4'h0} +: sgr_pkg::CLUSTER_SZ] == reqTargetBitmap
          && $countones(aff0Mask) == $countones(reqTargetBitmap))
      else $error("target mask misplaced");

   c_grp0_send: cover property (@(posedge clk_sys) disable iff (!rstn) sgiReqValid && reqGroup0);
   c_bcast_send: cover property (@(posedge clk_sys) disable iff (!rstn) sgiReqValid && reqBroadcast);
   c_trap_el2: cover property (@(posedge clk_sys) disable iff (!rstn) accTrap && accTrapEl == sgr_pkg::EL2);
   c_stall: cover property (@(posedge clk_sys) disable iff (!rstn) sgiReqValid && !sgiReqReady);

endmodule // sgr_generate
`default_nettype wire

// [tb/sgr_dist_model.sv]
// behavioural distributor that accepts generation requests
`timescale 1ns/1ps
`default_nettype none
module sgr_dist_model
(
   input  wire logic   clk_sys,
   input  wire logic   rstn,
   input  wire logic   slowMode,
   input  wire logic   sgiReqValid,
   output logic        sgiReqReady,
   output logic [7:0]  acceptCount
);
   logic [2:0] waitCnt;

   // slow mode delays acceptance by three pending cycles; nothing is refused for good
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         waitCnt     <= 3'h0;
         acceptCount <= 8'h00;
      end
      else if (sgiReqValid && sgiReqReady)
      begin
         waitCnt     <= 3'h0;
         acceptCount <= acceptCount + 8'h01; // acknowledged whatever the routing setup
      end
      else if (sgiReqValid)
      begin
         waitCnt <= waitCnt + 3'h1;
      end
   end

   // ready comes from registered waitCnt and the slowMode input, so it moves only after an edge or a slowMode change
   assign sgiReqReady = !slowMode || (waitCnt == 3'h3);
endmodule // sgr_dist_model
`default_nettype wire

// [tb/sgr_generate_tb.sv]
// self-checking bench for the software interrupt generation block
`timescale 1ns/1ps
`default_nettype none
module sgr_generate_tb;
   typedef struct packed
   {
      logic [15:0] ctl;
      logic [4:0]  cfg;
      logic [2:0]  op2;
      logic [63:0] data;
      logic [2:0]  exp;
   } sgr_row_s;

   // reserved ranges kept zero except in the last table row
   localparam logic [63:0] DA = 64'h00AB_0012_0534_8001;
   localparam logic [63:0] DB = 64'h0055_3012_0F34_FFFF;
   localparam logic [63:0] DC = 64'h0000_0100_0A00_00FF;
   localparam logic [63:0] DR = 64'hFF11_EE22_F733_0040;

   logic        clk_sys, rstn, sysWrValid, slowMode, sgiReqReady;
   logic [1:0]  sysOp0, accTrapEl;
   logic [2:0]  sysOp1, sysOp2;
   logic [3:0]  sysCrn, sysCrm, reqRangeSelector, reqInterruptIdentifier;
   logic [63:0] sysWrData;
   logic [15:0] ctl, reqTargetBitmap;
   logic [4:0]  cfg;
   logic [5:0]  accSyndrome;
   logic [7:0]  reqAffinityLevel3, reqAffinityLevel2, reqAffinityLevel1, acceptCount;
   logic        accUndefined, accTrap, sgiReqValid, reqBroadcast;
   logic        reqGroup0, reqSecure, reqNonsecureCheck;
   int          bad_count, samples_checked;

   // ctl: level, el2 on, el3 present, halted, sdd, early, sre1-3, tc, fmo, imo, route, ns
   // cfg: cpu range support, dist range support, drop, disable security, group 1 as 0
   // exp: 0 done, 1 undefined, 2-4 trap to level 1-3, 5 no outcome
   sgr_row_s rows [30] = '{
      '{16'h71C1, 5'h00, 3'h7, DA, 3'h0}, '{16'h71C1, 5'h00, 3'h5, DA, 3'h0},
      '{16'h31C1, 5'h00, 3'h7, DA, 3'h1}, '{16'h31C1, 5'h00, 3'h5, DA, 3'h1},
      '{16'h70C1, 5'h00, 3'h5, DA, 3'h2}, '{16'h71E1, 5'h00, 3'h5, DA, 3'h3},
      '{16'h71D1, 5'h00, 3'h7, DA, 3'h3}, '{16'h71C9, 5'h00, 3'h5, DA, 3'h3},
      '{16'h71C7, 5'h00, 3'h7, DA, 3'h4}, '{16'h7DC7, 5'h00, 3'h5, DA, 3'h1},
      '{16'h7EC7, 5'h00, 3'h7, DA, 3'h1}, '{16'h7CC7, 5'h00, 3'h7, DA, 3'h2},
      '{16'h70E1, 5'h00, 3'h5, DA, 3'h2}, '{16'h71E7, 5'h00, 3'h7, DA, 3'h3},
      '{16'h51F9, 5'h00, 3'h7, DA, 3'h0}, '{16'hB141, 5'h00, 3'h7, DA, 3'h3},
      '{16'hB1C7, 5'h00, 3'h5, DA, 3'h4}, '{16'hBDC7, 5'h00, 3'h7, DA, 3'h1},
      '{16'hBF47, 5'h00, 3'h5, DA, 3'h1}, '{16'hF181, 5'h00, 3'h7, DA, 3'h4},
      '{16'hF1C1, 5'h00, 3'h7, DA, 3'h0}, '{16'hF1C1, 5'h01, 3'h5, DA, 3'h0},
      '{16'hF1C1, 5'h00, 3'h5, DC, 3'h0}, '{16'h71C1, 5'h00, 3'h5, DB, 3'h0},
      '{16'h71C1, 5'h18, 3'h5, DB, 3'h0}, '{16'h71C1, 5'h14, 3'h5, DB, 3'h5},
      '{16'h71C1, 5'h10, 3'h5, DB, 3'h0}, '{16'h71C1, 5'h02, 3'h7, DA, 3'h0},
      '{16'h71C1, 5'h00, 3'h6, DA, 3'h5}, '{16'h71C1, 5'h00, 3'h7, DR, 3'h0}};

   sgr_generate i_sgr_generate
   (
      .clk_sys, .rstn, .sysWrValid, .sysOp0, .sysOp1, .sysCrn, .sysCrm, .sysOp2, .sysWrData,
      .curEl (ctl[15:14]), .el2Enabled (ctl[13]), .el3Present (ctl[12]), .halted (ctl[11]),
      .secureDebugDisabled (ctl[10]), .earlyUndefOption (ctl[9]), .sreEl1 (ctl[8]),
      .sreEl2 (ctl[7]), .sreEl3 (ctl[6]), .commonRegisterTrap (ctl[5]),
      .fiqRouteOverride (ctl[4]), .irqRouteOverride (ctl[3]), .monitorIrqFiqRoute (ctl[2:1]),
      .monitorNonsecureBit (ctl[0]), .cpuRangeSelectSupport (cfg[4]),
      .distRangeSelectSupport (cfg[3]), .dropOnBadRange (cfg[2]), .disableSecurity (cfg[1]),
      .grp1AsGroup0 (cfg[0]), .accUndefined, .accTrap, .accTrapEl, .accSyndrome,
      .sgiReqValid, .sgiReqReady, .reqAffinityLevel3, .reqAffinityLevel2, .reqAffinityLevel1,
      .reqRangeSelector, .reqTargetBitmap, .reqInterruptIdentifier, .reqBroadcast,
      .reqGroup0, .reqSecure, .reqNonsecureCheck
   );

   sgr_dist_model i_sgr_dist_model
   (
      .clk_sys, .rstn, .slowMode, .sgiReqValid, .sgiReqReady, .acceptCount
   );

   // free-running system clock
   always #12.5 clk_sys = ~clk_sys;

   task automatic end_of_test();
      $display("checks %0d wrong %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // offer one write; returns just after the edge where the answer lands
   task automatic wr(input sgr_row_s r);
      @(posedge clk_sys);
      ctl        <= r.ctl;
      cfg        <= r.cfg;
      sysOp2     <= r.op2;
      sysWrData  <= r.data;
      sysWrValid <= 1'b1;
      @(posedge clk_sys);
      sysWrValid <= 1'b0;
      #1;
   endtask

   // bounded wait for the distributor to take the pending request
   task automatic drain();
      for (int i = 0; i < 20 && sgiReqValid === 1'b1; i++)
      begin
         @(posedge clk_sys);
         #1;
      end
      if (sgiReqValid !== 1'b0)
      begin
         chk(sgiReqValid, 64'h0);
         end_of_test();
      end
   endtask

   task automatic chkIdle();
      chk({sgiReqValid, accTrap, accUndefined, accSyndrome}, 64'h0);
      chk({reqTargetBitmap, reqInterruptIdentifier, reqGroup0, reqSecure}, 64'h0);
   endtask

   task automatic chkRow(input sgr_row_s r);
      logic        bc, sec, trap;
      logic [23:0] aff;
      bc   = r.data[40];
      sec  = (r.ctl[15:14] == 2'h3) || !r.ctl[0];
      trap = r.exp inside {3'h2, 3'h3, 3'h4};
      aff  = {r.data[55:48], r.data[39:32], r.data[23:16]};
      chk(accUndefined, r.exp == 3'h1);
      chk(accTrap, trap);
      chk(accSyndrome, trap ? 6'h18 : 6'h00);
      if (trap)
         chk(accTrapEl, r.exp - 3'h1);
      chk(sgiReqValid, r.exp == 3'h0);
      if (r.exp == 3'h0)
      begin
         chk(reqBroadcast, bc);
         chk(reqInterruptIdentifier, r.data[27:24]);
         chk(reqTargetBitmap, bc ? 16'h0000 : r.data[15:0]);
         if (!bc)
            chk({reqAffinityLevel3, reqAffinityLevel2, reqAffinityLevel1}, aff);
         chk(reqRangeSelector, (r.cfg[4] && r.cfg[3]) ? r.data[47:44] : 4'h0);
         chk(reqSecure, sec);
         chk(reqGroup0, (r.op2 == 3'h7) || r.cfg[0]);
         chk(reqNonsecureCheck, (r.op2 == 3'h7) && !sec && !r.cfg[1]);
      end
   endtask

   initial
   begin
      logic [7:0] base;
      {clk_sys, rstn, sysWrValid, slowMode, sysOp2, sysWrData} = '0;
      {sysOp0, sysOp1, sysCrn, sysCrm} = {sgr_pkg::SYS_OP0, sgr_pkg::SYS_OP1,
                                          sgr_pkg::SYS_CRN, sgr_pkg::SYS_CRM};
      ctl = 16'h71C1;
      cfg = 5'h00;
      bad_count = 0;
      samples_checked = 0;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      #1;
      chkIdle();
      // ordinary cases: one write per row, prompt distributor
      foreach (rows[i])
      begin
         wr(rows[i]);
         chkRow(rows[i]);
         drain();
      end
      $display("table rows done");
      // slow distributor; a write offered while pending must vanish
      @(posedge clk_sys);
      slowMode <= 1'b1;
      base = acceptCount;
      wr(rows[0]);
      @(posedge clk_sys);
      sysWrData  <= DC;
      sysWrValid <= 1'b1;
      @(posedge clk_sys);
      sysWrValid <= 1'b0;
      #1;
      chk(sgiReqValid, 1'b1);
      chk({reqBroadcast, reqInterruptIdentifier}, 5'h05);
      drain();
      repeat (2) @(posedge clk_sys);
      #1;
      chk(sgiReqValid, 1'b0);
      chk(acceptCount, base + 8'h01);
      $display("slow distributor done");
      // reset while a request is pending
      wr(rows[20]);
      @(posedge clk_sys);
      rstn <= 1'b0;
      #1;
      chkIdle();
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      slowMode <= 1'b0;
      #1;
      chkIdle();
      $display("reset test done");
      // back to back: second write taken on the edge the first is accepted
      base = acceptCount;
      @(posedge clk_sys);
      sysOp2     <= 3'h7;
      sysWrData  <= DA;
      sysWrValid <= 1'b1;
      @(posedge clk_sys);
      sysWrData <= DB;
      #1;
      chk(reqInterruptIdentifier, 4'h5);
      @(posedge clk_sys);
      sysWrValid <= 1'b0;
      #1;
      chk({sgiReqValid, reqInterruptIdentifier}, 5'h1F);
      drain();
      chk(acceptCount, base + 8'h02);
      $display("back to back done");
      end_of_test();
   end
endmodule // sgr_generate_tb
`default_nettype wire
